// >>> fsq_sfr_port.sv
package fsq_pkg;
  // Own register map (APB byte offsets)
  localparam logic [7:0]  REG_CMD        = 8'h00;
  localparam logic [7:0]  REG_PAGE       = 8'h04;
  localparam logic [7:0]  REG_STATUS     = 8'h08;
  localparam logic [7:0]  REG_BIDX       = 8'h0c;
  localparam logic [7:0]  REG_BDATA      = 8'h10;
  // Command register fields
  localparam int unsigned CMD_OP_LSB     = 0;
  localparam int unsigned CMD_GO_BIT     = 8;
  // Status register fields
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_DONE_BIT    = 1;
  localparam int unsigned ST_ERR_BIT     = 2;
  localparam int unsigned ST_RB_LSB      = 16;
  // Page register fields
  localparam int unsigned PG_PAGE_LSB    = 16;
  // Device flash_op_control layout
  localparam logic [3:0]  OP_PAGE_ERASE  = 4'h2;
  localparam logic [3:0]  OP_ROW_PROG    = 4'h1;
  localparam int unsigned CTL_ERASE_BIT  = 6;
  localparam int unsigned CTL_PERMIT_BIT = 14;
  localparam int unsigned CTL_START_BIT  = 15;
  localparam logic [15:0] CTL_RESET      = 16'h0000;
  localparam logic [15:0] KEY_FIRST      = 16'h0055;
  localparam logic [15:0] KEY_SECOND     = 16'h00aa;
  // Device register addresses on its special-function bus (arbitrary values)
  localparam logic [15:0] DEV_CTRL_ADDR  = 16'h0010;
  localparam logic [15:0] DEV_KEY_ADDR   = 16'h0012;
  localparam logic [15:0] DEV_PAGE_ADDR  = 16'h0014;
  // Geometry and pacing
  localparam int unsigned ROW_WORDS      = 64;
  localparam int unsigned PAGE_ROWS      = 8;
  localparam int unsigned NOP_SLOTS      = 2;
  localparam int unsigned POLL_GAP       = 4;
  typedef enum logic [1:0] {
    XFER_WR,
    XFER_RD,
    XFER_TBL_LO,
    XFER_TBL_HI
  } fsq_xfer_t;
endpackage : fsq_pkg

`timescale 1ns/1ns
module fsq_sfr_port
  import fsq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              req,
  input  wire fsq_pkg::fsq_xfer_t kind,
  input  wire logic [15:0]       addr,
  input  wire logic [15:0]       wdata,
  output logic                   busy,
  output logic                   done,
  output logic [15:0]            rdata,
  output logic [15:0]            dev_addr,
  output logic [15:0]            dev_wdata,
  output logic                   dev_sfr_we,
  output logic                   dev_sfr_re,
  output logic                   dev_tbl_wl,
  output logic                   dev_tbl_wh,
  input  wire logic [15:0]       dev_rdata,
  input  wire logic              dev_stall
);
  logic strobe_cycle;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy         <= 1'b0;
      done         <= 1'b0;
      rdata        <= 16'h0000;
      strobe_cycle <= 1'b0;
      dev_addr     <= 16'h0000;
      dev_wdata    <= 16'h0000;
      dev_sfr_we   <= 1'b0;
      dev_sfr_re   <= 1'b0;
      dev_tbl_wl   <= 1'b0;
      dev_tbl_wh   <= 1'b0;
    end else begin
      done       <= 1'b0;
      dev_sfr_we <= 1'b0;
      dev_sfr_re <= 1'b0;
      dev_tbl_wl <= 1'b0;
      dev_tbl_wh <= 1'b0;
      if (!busy && req) begin
        busy         <= 1'b1;
        strobe_cycle <= 1'b1;
        dev_addr     <= addr;
        dev_wdata    <= wdata;
        dev_sfr_we   <= (kind == XFER_WR);
        dev_sfr_re   <= (kind == XFER_RD);
        dev_tbl_wl   <= (kind == XFER_TBL_LO);
        dev_tbl_wh   <= (kind == XFER_TBL_HI);
      end else if (strobe_cycle) begin
        strobe_cycle <= 1'b0;
      end else if (busy && !dev_stall) begin
        // Stall covers a running flash cycle; no access completes under it
        busy  <= 1'b0;
        done  <= 1'b1;
        rdata <= dev_rdata;
      end
    end
  end
endmodule : fsq_sfr_port

// >>> fsq_ctrl.sv
// Contract
// - Software saves and edits page before erase
// - Program: field 0001, erase clear, permit set
// - Page start address into page pointer first
// - Table write sets erase block base address
// - Keys 0x55 then 0xAA before each start
// - Load 64 instructions into buffers first
// - Repeat rows, incrementing page pointer each time
// - Wait for completion before trusting result
// - Two idle slots after the start write
// - Keep unlock and start sequence uninterrupted
`timescale 1ns/1ns
module fsq_ctrl
  import fsq_pkg::*;
#(
  parameter int unsigned ROW_LEN = fsq_pkg::ROW_WORDS
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [15:0]      dev_addr,
  output logic [15:0]      dev_wdata,
  output logic             dev_sfr_we,
  output logic             dev_sfr_re,
  output logic             dev_tbl_wl,
  output logic             dev_tbl_wh,
  input  wire logic [15:0] dev_rdata,
  input  wire logic        dev_stall
);
  localparam int unsigned IW = $clog2(ROW_LEN);

  typedef enum {
    S_IDLE,
    S_CTRL,
    S_PAGE,
    S_TBL_LO,
    S_TBL_HI,
    S_KEY1,
    S_KEY2,
    S_START,
    S_NOPS,
    S_POLL,
    S_GAP
  } fsq_state_t;

  fsq_state_t        state;
  logic [23:0]       row_buf [ROW_LEN];
  logic [IW-1:0]     buf_idx;
  logic [IW-1:0]     word_idx;
  logic [7:0]        tbl_page;
  logic [15:0]       tbl_off;
  logic [3:0]        op_sel;
  logic              done_flag;
  logic              err_flag;
  logic [15:0]       ctrl_rb;
  logic [3:0]        wait_cnt;
  logic              port_req;
  fsq_xfer_t         port_kind;
  logic [15:0]       port_addr;
  logic [15:0]       port_wdata;
  logic              port_busy;
  logic              port_done;
  logic [15:0]       port_rdata;
  logic              pend;
  logic              busy;
  logic              wr_acc;
  logic              rd_acc;
  logic              go_req;
  logic              op_ok;
  logic              op_end;
  logic [15:0]       ctrl_word;
  logic [15:0]       word_addr;

  assign busy   = (state != S_IDLE);
  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_acc = psel && penable && !pready && !pwrite;
  assign go_req = wr_acc && (paddr == REG_CMD) && pwdata[CMD_GO_BIT];
  assign op_ok  = (pwdata[CMD_OP_LSB +: 4] == OP_PAGE_ERASE) ||
                  (pwdata[CMD_OP_LSB +: 4] == OP_ROW_PROG);
  assign op_end = port_done && (state == S_POLL) && !port_rdata[CTL_START_BIT];
  assign word_addr = tbl_off + {{(15 - IW){1'b0}}, word_idx, 1'b0};

  // Control word: permit always set so start is never ignored
  always_comb begin
    ctrl_word = CTL_RESET;
    ctrl_word[3:0] = op_sel;
    ctrl_word[CTL_PERMIT_BIT] = 1'b1;
    ctrl_word[CTL_ERASE_BIT] = (op_sel == OP_PAGE_ERASE);
  end

  // APB slave: one wait state, answer registered
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          REG_CMD: begin
            prdata[CMD_OP_LSB +: 4] <= op_sel;
            prdata[CMD_GO_BIT]      <= busy;
          end
          REG_PAGE: begin
            prdata[PG_PAGE_LSB +: 8] <= tbl_page;
            prdata[15:0]             <= tbl_off;
          end
          REG_STATUS: begin
            prdata[ST_BUSY_BIT]      <= busy;
            prdata[ST_DONE_BIT]      <= done_flag;
            prdata[ST_ERR_BIT]       <= err_flag;
            prdata[ST_RB_LSB +: 16]  <= ctrl_rb;
          end
          REG_BIDX: prdata[IW-1:0] <= buf_idx;
          REG_BDATA: prdata[23:0] <= rd_acc ? row_buf[buf_idx] : 24'h000000;
          default: pslverr <= 1'b1;
        endcase
        // Changing page or buffer mid-operation would corrupt the row
        if (pwrite && busy && (paddr == REG_PAGE || paddr == REG_BDATA ||
                               paddr == REG_BIDX)) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Row holding buffer, auto-incrementing index
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      buf_idx <= '0;
    end else if (wr_acc && !busy) begin
      if (paddr == REG_BIDX) begin
        buf_idx <= pwdata[IW-1:0];
      end else if (paddr == REG_BDATA) begin
        row_buf[buf_idx] <= pwdata[23:0];
        buf_idx          <= buf_idx + 1'b1;
      end
    end
  end

  // Page pointer; advances after each row so software can stream a page
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tbl_page <= 8'h00;
      tbl_off  <= 16'h0000;
    end else if (op_end && op_sel == OP_ROW_PROG) begin
      tbl_page <= tbl_page + 8'h01;
    end else if (wr_acc && !busy && paddr == REG_PAGE) begin
      tbl_page <= pwdata[PG_PAGE_LSB +: 8];
      tbl_off  <= pwdata[15:0];
    end
  end

  // Sticky flags; hardware set wins over software clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_flag <= 1'b0;
      err_flag  <= 1'b0;
    end else begin
      if (op_end) begin
        done_flag <= 1'b1;
      end else if (wr_acc && paddr == REG_STATUS && pwdata[ST_DONE_BIT]) begin
        done_flag <= 1'b0;
      end
      if (go_req && (busy || !op_ok)) begin
        err_flag <= 1'b1;
      end else if (wr_acc && paddr == REG_STATUS && pwdata[ST_ERR_BIT]) begin
        err_flag <= 1'b0;
      end
    end
  end

  // Sequencer; key and start writes run back to back with nothing between
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state      <= S_IDLE;
      op_sel     <= 4'h0;
      word_idx   <= '0;
      wait_cnt   <= 4'h0;
      pend       <= 1'b0;
      port_req   <= 1'b0;
      port_kind  <= XFER_WR;
      port_addr  <= 16'h0000;
      port_wdata <= 16'h0000;
      ctrl_rb    <= CTL_RESET;
    end else begin
      port_req <= 1'b0;
      if (port_done) begin
        pend <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (go_req && op_ok) begin
            op_sel   <= pwdata[CMD_OP_LSB +: 4];
            word_idx <= '0;
            state    <= S_CTRL;
          end
        end
        S_CTRL: begin
          if (!pend && !port_req && !port_busy) begin
            port_req   <= 1'b1;
            pend       <= 1'b1;
            port_kind  <= XFER_WR;
            port_addr  <= DEV_CTRL_ADDR;
            port_wdata <= ctrl_word;
          end else if (port_done) begin
            state <= S_PAGE;
          end
        end
        S_PAGE: begin
          if (!pend && !port_req && !port_busy) begin
            port_req   <= 1'b1;
            pend       <= 1'b1;
            port_kind  <= XFER_WR;
            port_addr  <= DEV_PAGE_ADDR;
            port_wdata <= {8'h00, tbl_page};
          end else if (port_done) begin
            state <= S_TBL_LO;
          end
        end
        S_TBL_LO: begin
          if (!pend && !port_req && !port_busy) begin
            port_req  <= 1'b1;
            pend      <= 1'b1;
            port_kind <= XFER_TBL_LO;
            // Erase: dummy write latches block base; program: buffer load
            port_addr <= (op_sel == OP_PAGE_ERASE) ? tbl_off : word_addr;
            port_wdata <= (op_sel == OP_PAGE_ERASE) ? tbl_off : row_buf[word_idx][15:0];
          end else if (port_done) begin
            state <= (op_sel == OP_PAGE_ERASE) ? S_KEY1 : S_TBL_HI;
          end
        end
        S_TBL_HI: begin
          if (!pend && !port_req && !port_busy) begin
            port_req   <= 1'b1;
            pend       <= 1'b1;
            port_kind  <= XFER_TBL_HI;
            port_addr  <= word_addr;
            port_wdata <= {8'h00, row_buf[word_idx][23:16]};
          end else if (port_done) begin
            word_idx <= word_idx + 1'b1;
            // Exactly one row of words before a single program cycle
            state <= (word_idx == IW'(ROW_LEN - 1)) ? S_KEY1 : S_TBL_LO;
          end
        end
        S_KEY1: begin
          if (!pend && !port_req && !port_busy) begin
            port_req   <= 1'b1;
            pend       <= 1'b1;
            port_kind  <= XFER_WR;
            port_addr  <= DEV_KEY_ADDR;
            port_wdata <= KEY_FIRST;
          end else if (port_done) begin
            state <= S_KEY2;
          end
        end
        S_KEY2: begin
          if (!pend && !port_req && !port_busy) begin
            port_req   <= 1'b1;
            pend       <= 1'b1;
            port_kind  <= XFER_WR;
            port_addr  <= DEV_KEY_ADDR;
            port_wdata <= KEY_SECOND;
          end else if (port_done) begin
            state <= S_START;
          end
        end
        S_START: begin
          if (!pend && !port_req && !port_busy) begin
            port_req   <= 1'b1;
            pend       <= 1'b1;
            port_kind  <= XFER_WR;
            port_addr  <= DEV_CTRL_ADDR;
            port_wdata <= ctrl_word | (16'h0001 << CTL_START_BIT);
          end else if (port_done) begin
            wait_cnt <= 4'(NOP_SLOTS);
            state    <= S_NOPS;
          end
        end
        S_NOPS: begin
          if (wait_cnt == 4'h0) begin
            state <= S_POLL;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        S_POLL: begin
          if (!pend && !port_req && !port_busy) begin
            port_req  <= 1'b1;
            pend      <= 1'b1;
            port_kind <= XFER_RD;
            port_addr <= DEV_CTRL_ADDR;
          end else if (port_done) begin
            ctrl_rb <= port_rdata;
            if (port_rdata[CTL_START_BIT]) begin
              wait_cnt <= 4'(POLL_GAP);
              state    <= S_GAP;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_GAP: begin
          if (wait_cnt == 4'h0) begin
            state <= S_POLL;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  fsq_sfr_port u_port (
    .clk        (clk),
    .reset_n    (reset_n),
    .req        (port_req),
    .kind       (port_kind),
    .addr       (port_addr),
    .wdata      (port_wdata),
    .busy       (port_busy),
    .done       (port_done),
    .rdata      (port_rdata),
    .dev_addr   (dev_addr),
    .dev_wdata  (dev_wdata),
    .dev_sfr_we (dev_sfr_we),
    .dev_sfr_re (dev_sfr_re),
    .dev_tbl_wl (dev_tbl_wl),
    .dev_tbl_wh (dev_tbl_wh),
    .dev_rdata  (dev_rdata),
    .dev_stall  (dev_stall)
  );
endmodule : fsq_ctrl

// >>> fsq_ctrl_chk.sv
`timescale 1ns/1ns
module fsq_ctrl_chk
  import fsq_pkg::*;
#(
  parameter int unsigned ROW_LEN = 64
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] dev_addr,
  input wire logic [15:0] dev_wdata,
  input wire logic        dev_sfr_we,
  input wire logic        dev_sfr_re,
  input wire logic        dev_tbl_wl,
  input wire logic        dev_tbl_wh,
  input wire logic [15:0] dev_rdata,
  input wire logic        dev_stall
);
  logic [2:0]  last;
  logic [15:0] lo_addr;
  logic [15:0] hi_cnt;
  logic        pg_seen;
  logic        lo_seen;
  wire any_stb = dev_sfr_we | dev_sfr_re | dev_tbl_wl | dev_tbl_wh;
  wire ctl_wr  = dev_sfr_we && dev_addr == DEV_CTRL_ADDR;
  wire start   = ctl_wr && dev_wdata[CTL_START_BIT];
  wire key_wr  = dev_sfr_we && dev_addr == DEV_KEY_ADDR;
  // Kind of the previous strobe: 1 first key, 2 second key, 3 table low, 4 other
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      last <= 3'd0;
      lo_addr <= 16'h0000;
    end else if (any_stb) begin
      last <= (key_wr && dev_wdata == KEY_FIRST) ? 3'd1 :
              (key_wr && dev_wdata == KEY_SECOND) ? 3'd2 : dev_tbl_wl ? 3'd3 : 3'd4;
      lo_addr <= dev_tbl_wl ? dev_addr : lo_addr;
    end
  end
  // A setup write of the control register opens a new operation
  always_ff @(posedge clk) begin
    if (!reset_n || (ctl_wr && !dev_wdata[CTL_START_BIT])) begin
      hi_cnt <= 16'h0000;
      pg_seen <= 1'b0;
      lo_seen <= 1'b0;
    end else begin
      hi_cnt <= hi_cnt + {15'h0000, dev_tbl_wh};
      pg_seen <= pg_seen | (dev_sfr_we && dev_addr == DEV_PAGE_ADDR);
      lo_seen <= lo_seen | dev_tbl_wl;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_key_order: assert property (key_wr && dev_wdata == KEY_SECOND |-> last == 3'd1)
    else $error("second key without first key");
  a_start_keyed: assert property (start |-> last == 3'd2)
    else $error("start write not right after key pair");
  a_start_gap: assert property (start |=> !any_stb [*2])
    else $error("transfer inside idle slots after start");
  a_start_value: assert property (start |-> dev_wdata == 16'hc042 || dev_wdata == 16'hc001)
    else $error("start write with wrong control value");
  a_stall_quiet: assert property (dev_stall |-> !any_stb)
    else $error("transfer issued while device stalls");
  a_row_count: assert property (start && dev_wdata[3:0] == OP_ROW_PROG |-> hi_cnt == 16'(ROW_LEN))
    else $error("row program with wrong word count");
  a_erase_base: assert property (start && dev_wdata[3:0] == OP_PAGE_ERASE |-> pg_seen && lo_seen)
    else $error("erase started without page and base set");
  a_word_pair: assert property (dev_tbl_wh |-> last == 3'd3 && dev_addr == lo_addr)
    else $error("high table write not paired with low");
endmodule : fsq_ctrl_chk

bind fsq_ctrl fsq_ctrl_chk #(.ROW_LEN(ROW_LEN)) u_chk (
  .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_sfr_we(dev_sfr_we), .dev_sfr_re(dev_sfr_re),
  .dev_tbl_wl(dev_tbl_wl), .dev_tbl_wh(dev_tbl_wh), .dev_rdata(dev_rdata), .dev_stall(dev_stall)
);

// >>> fsq_dev_model.sv
`timescale 1ns/1ns
module fsq_dev_model
  import fsq_pkg::*;
#(
  parameter int unsigned OP_CYCLES = 40
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] dev_addr,
  input  wire logic [15:0] dev_wdata,
  input  wire logic        dev_sfr_we,
  input  wire logic        dev_sfr_re,
  input  wire logic        dev_tbl_wl,
  input  wire logic        dev_tbl_wh,
  input  wire logic        slow,
  output logic [15:0]      dev_rdata,
  output logic             dev_stall,
  output logic [7:0]       erase_cnt,
  output logic [7:0]       prog_cnt,
  output logic [7:0]       op_page,
  output logic [7:0]       row_words
);
  logic [15:0] ctrl;
  logic [7:0]  page;
  logic [1:0]  key;
  logic [7:0]  busy;
  logic [7:0]  words;
  logic        hold;
  logic        rv;
  wire wr = dev_sfr_we | dev_tbl_wl | dev_tbl_wh;
  wire kw = dev_sfr_we && dev_addr == DEV_KEY_ADDR;
  wire go = dev_sfr_we && dev_addr == DEV_CTRL_ADDR && dev_wdata[CTL_START_BIT] && key == 2'd2
            && dev_wdata[CTL_PERMIT_BIT]
            && (dev_wdata[3:0] == OP_PAGE_ERASE && dev_wdata[CTL_ERASE_BIT]
            || dev_wdata[3:0] == OP_ROW_PROG && !dev_wdata[CTL_ERASE_BIT]);
  assign dev_stall = busy != 8'h00 || hold;
  always_ff @(posedge clk) begin
    if (!reset_n)
      key <= 2'd0;
    else if (kw && dev_wdata == KEY_FIRST)
      key <= 2'd1;
    else if (kw && dev_wdata == KEY_SECOND && key == 2'd1)
      key <= 2'd2;
    else if (wr)
      key <= 2'd0;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl <= CTL_RESET;
      {page, busy, words, erase_cnt, prog_cnt, op_page, row_words, hold} <= '0;
    end else begin
      hold <= slow & (wr | dev_sfr_re);
      if (dev_sfr_we && dev_addr == DEV_PAGE_ADDR) page <= dev_wdata[7:0];
      if (dev_tbl_wh) words <= words + 8'd1;
      if (dev_sfr_we && dev_addr == DEV_CTRL_ADDR) ctrl <= {go, dev_wdata[14:0]};
      if (busy != 8'h00) busy <= busy - 8'd1;
      if (busy == 8'd1) ctrl[CTL_START_BIT] <= 1'b0;
      if (go) begin
        busy <= 8'(OP_CYCLES);
        op_page <= page;
        row_words <= words;
        words <= 8'd0;
        erase_cnt <= erase_cnt + {7'd0, dev_wdata[CTL_ERASE_BIT]};
        prog_cnt <= prog_cnt + {7'd0, !dev_wdata[CTL_ERASE_BIT]};
      end
    end
  end
  // Read data holds until the stall ends, then churns so stale data never looks valid
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dev_rdata <= 16'h0000;
      rv <= 1'b0;
    end else begin
      rv <= dev_sfr_re || (rv && dev_stall);
      if (dev_sfr_re) dev_rdata <= dev_addr == DEV_CTRL_ADDR ? ctrl : {8'h00, page};
      else if (!rv) dev_rdata <= ~dev_rdata;
    end
  end
endmodule : fsq_dev_model

// >>> flash_row_program_sequencer_tb_top.sv
`timescale 1ns/1ns
module flash_row_program_sequencer_tb_top;
  import fsq_pkg::*;
  localparam int unsigned ROW = 8;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, slow, err;
  logic        dev_sfr_we, dev_sfr_re, dev_tbl_wl, dev_tbl_wh, dev_stall;
  logic [7:0]  paddr, erase_cnt, prog_cnt, op_page, row_words;
  logic [15:0] dev_addr, dev_wdata, dev_rdata;
  logic [31:0] pwdata, prdata, rd, st;
  int          errors, check_count, cycles;

  fsq_ctrl #(.ROW_LEN(ROW)) u_dut (
    .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_sfr_we(dev_sfr_we),
    .dev_sfr_re(dev_sfr_re), .dev_tbl_wl(dev_tbl_wl), .dev_tbl_wh(dev_tbl_wh),
    .dev_rdata(dev_rdata), .dev_stall(dev_stall));
  fsq_dev_model u_dev (
    .clk(clk), .reset_n(reset_n), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_sfr_we(dev_sfr_we), .dev_sfr_re(dev_sfr_re), .dev_tbl_wl(dev_tbl_wl),
    .dev_tbl_wh(dev_tbl_wh), .slow(slow), .dev_rdata(dev_rdata), .dev_stall(dev_stall),
    .erase_cnt(erase_cnt), .prog_cnt(prog_cnt), .op_page(op_page), .row_words(row_words));

  always #2 clk = ~clk;

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // No per-wait limit here: the cycle ceiling below ends any hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_done();
    do apb(REG_STATUS, 1'b0, 32'h0); while (rd[ST_DONE_BIT] !== 1'b1);
    st = rd;
    apb(REG_STATUS, 1'b1, 32'h2);
  endtask : wait_done

  task automatic t_regs();
    apb(REG_STATUS, 1'b0, 32'h0);
    check("status reset", rd, 32'h0);
    apb(8'h40, 1'b0, 32'h0);
    check("unmapped error", err, 1'b1);
  endtask : t_regs

  task automatic t_erase(input logic [7:0] pg);
    logic [7:0] n;
    n = erase_cnt;
    apb(REG_PAGE, 1'b1, {8'h00, pg, 16'h0000});
    apb(REG_CMD, 1'b1, 32'h102);
    wait_done();
    check("erase count", erase_cnt, n + 8'd1);
    check("erase page", op_page, pg);
    check("erase readback", st[31:16], 16'h4042);
  endtask : t_erase

  task automatic t_prog(input logic [7:0] pg);
    logic [7:0] n;
    n = prog_cnt;
    apb(REG_BIDX, 1'b1, 32'h0);
    for (int i = 0; i < ROW; i++)
      apb(REG_BDATA, 1'b1, 32'h5a3c00 + i);
    apb(REG_BIDX, 1'b1, 32'h1);
    apb(REG_BDATA, 1'b0, 32'h0);
    check("buffer word", rd & 32'hffffff, 32'h5a3c01);
    apb(REG_PAGE, 1'b1, {8'h00, pg, 16'h0000});
    apb(REG_CMD, 1'b1, 32'h101);
    wait_done();
    check("program count", prog_cnt, n + 8'd1);
    check("row words", row_words, ROW);
    check("row page", op_page, pg);
    check("program readback", st[31:16], 16'h4001);
    apb(REG_CMD, 1'b1, 32'h101);
    wait_done();
    check("next row page", op_page, pg + 8'd1);
    check("second row words", row_words, ROW);
    apb(REG_PAGE, 1'b0, 32'h0);
    check("page pointer", rd, {8'h00, pg + 8'd2, 16'h0000});
  endtask : t_prog

  task automatic t_refuse(input logic [7:0] pg);
    logic [7:0] n;
    n = erase_cnt + prog_cnt;
    apb(REG_CMD, 1'b1, 32'h103);
    apb(REG_STATUS, 1'b0, 32'h0);
    check("bad op flagged", rd[ST_ERR_BIT], 1'b1);
    check("bad op ignored", erase_cnt + prog_cnt, n);
    apb(REG_STATUS, 1'b1, 32'h4);
    apb(REG_STATUS, 1'b0, 32'h0);
    check("error cleared", rd[ST_ERR_BIT], 1'b0);
    apb(REG_CMD, 1'b1, 32'h102);
    apb(REG_PAGE, 1'b1, 32'h00ff0000);
    check("page write busy", err, 1'b1);
    apb(REG_CMD, 1'b0, 32'h0);
    check("command busy", rd, 32'h102);
    wait_done();
    check("erase page kept", op_page, pg);
  endtask : t_refuse

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {psel, penable, pwrite, slow, paddr, pwdata} = '0;
    errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_erase(8'h03);
    slow <= 1'b1;
    t_prog(8'h10);
    t_refuse(8'h12);
    end_sim();
  end
endmodule : flash_row_program_sequencer_tb_top
